// File: design/ssp_mem.sv
// byte-wide array with registered read data
`timescale 1ns/1ps
module ssp_mem
  import ssp_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              we_i,
  input  wire logic [MEM_AW-1:0] waddr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [MEM_AW-1:0] raddr_i,
  output logic      [7:0]        rdata_o
);

  logic [7:0] mem [MEM_DEPTH];

  // one write port, one registered read port
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// File: design/ssp_pkg.sv
// constants and types shared by the serial sram pin interface
package ssp_pkg;

  // memory array geometry
  localparam int         MEM_AW     = 18;
  localparam int         MEM_DEPTH  = 262144;
  localparam int         PAGE_BITS  = 5;

  // instruction codes
  localparam logic [7:0] CMD_READ            = 8'h03;
  localparam logic [7:0] CMD_WRITE           = 8'h02;
  localparam logic [7:0] READ_MODE_REG_CMD   = 8'h05;
  localparam logic [7:0] WRITE_MODE_REG_CMD  = 8'h01;
  localparam logic [7:0] ENTER_DUAL_CMD      = 8'h3b;
  localparam logic [7:0] ENTER_QUAD_CMD      = 8'h38;
  localparam logic [7:0] EXIT_MULTI_IO_CMD   = 8'hff;

  // sequence lengths in bits and read latency in serial clocks
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS  = 6'h18;
  localparam logic [5:0] DATA_BITS  = 6'h08;
  localparam logic [5:0] LAT_SINGLE = 6'h08;
  localparam logic [5:0] LAT_DUAL   = 6'h04;
  localparam logic [5:0] LAT_QUAD   = 6'h02;

  // mode register layout
  localparam int         MR_MODE_HI = 7;
  localparam int         MR_MODE_LO = 6;
  localparam logic [7:0] MR_RESET   = 8'h40;
  localparam logic [1:0] AM_BYTE    = 2'h0;
  localparam logic [1:0] AM_PAGE    = 2'h2;
  localparam logic [1:0] AM_SEQ     = 2'h1;

  // register bus map
  localparam int         AXI_AW       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam int         CTRL_EN_BIT  = 0;
  localparam int         CTRL_EXIT_BIT = 1;
  localparam logic       CTRL_EN_RST  = 1'b1;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // pin synchroniser reset: chip select idle high, rest low
  localparam logic [5:0] PIN_SYNC_RST = 6'h20;

  typedef enum logic [1:0] {IO_SINGLE, IO_DUAL, IO_QUAD} ssp_io_e;
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_MRD, ST_MWR, ST_IGNORE
  } ssp_state_e;

endpackage

// File: design/ssp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssp_sync
  import ssp_pkg::*;
#(
  parameter int           W       = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssp_sync_s;

  ssp_sync_s q, d;

  // first stage feeds only the second
  always_comb begin
    d        = q;
    d.meta   = async_i;
    d.stable = q.meta;
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.stable;

endmodule

// File: design/ssp_top.sv
// serial sram pin interface with its array and a register slave
//
// Summary of operation
// - low chip select selects, high means standby
// - deselected device never drives output line
// - input bits sampled on serial clock rise
// - output bits change only after clock fall
// - pause freezes sequence state, never restarts it
// - pause entry waits for clock low
// - paused device ignores clock and input
// - resume waits for clock low
// - output released and driven with pause level
// - no pause in quad mode
// - dual mode uses lines 0,1 both ways
// - quad uses four lines, spare otherwise idle
// - read latency 8, 4, 2 clocks
// - array of 256K bytes
// - byte, page, sequential access for both
// - 8-bit instruction, 24-bit address, msb first
// - read, write, mode register codes decoded
// - dual, quad entry and exit instructions
// - mode register bits 7:6 pick access
`timescale 1ns/1ps
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // serial pins
  input  wire logic              chip_select_n_i,
  input  wire logic              serial_clock_i,
  input  wire logic [3:0]        io_line_i,
  output logic      [3:0]        io_line_o,
  output logic      [3:0]        io_line_oe_o,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  typedef struct packed {
    ssp_state_e        st;
    ssp_io_e           io;
    logic              is_rd;
    logic              first;
    logic              paused;
    logic              sck_prev;
    logic [5:0]        cnt;
    logic [31:0]       sh;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        mr;
    logic [7:0]        tx;
    logic [3:0]        tx_cnt;
    logic [3:0]        io_o;
    logic [3:0]        io_oe;
    logic              ctrl_en;
    logic              aw_got;
    logic              w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ssp_main_s;

  localparam ssp_main_s MAIN_RST = '{
    st: ST_CMD, io: IO_SINGLE, mr: MR_RESET, ctrl_en: CTRL_EN_RST, default: '0
  };

  ssp_main_s         q, d;
  logic [5:0]        pins_s;
  logic              cs_n_s, sck_s, pause_n_s;
  logic [3:0]        io_s;
  logic              sel, sck_rise, sck_fall, hold_low;
  logic              mem_we;
  logic [7:0]        mem_wdata;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0]        mem_rdata;
  logic [31:0]       sh_n;
  logic [5:0]        cnt_n;
  logic [5:0]        bpc;
  logic [1:0]        amode;

  // bits moved per serial clock
  function automatic logic [5:0] lines_of(input ssp_io_e io);
    case (io)
      IO_DUAL: lines_of = 6'h02;
      IO_QUAD: lines_of = 6'h04;
      default: lines_of = 6'h01;
    endcase
  endfunction

  // next array address for the current access mode
  function automatic logic [MEM_AW-1:0] next_addr(input logic [MEM_AW-1:0] a,
                                                  input logic [1:0]        am);
    logic [MEM_AW-1:0] inc;
    inc = a + 18'h00001;
    if (am == AM_PAGE) begin
      next_addr = {a[MEM_AW-1:PAGE_BITS], inc[PAGE_BITS-1:0]};
    end else begin
      next_addr = inc;
    end
  endfunction

  // pins pass two flip-flops before any use
  ssp_sync #(
    .W       (6),
    .RST_VAL (PIN_SYNC_RST)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({chip_select_n_i, serial_clock_i, io_line_i}),
    .sync_o    (pins_s)
  );

  ssp_mem u_mem (
    .ref_clk_i (ref_clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .raddr_i   (q.addr),
    .rdata_o   (mem_rdata)
  );

  assign cs_n_s    = pins_s[5];
  assign sck_s     = pins_s[4];
  assign io_s      = pins_s[3:0];
  assign pause_n_s = pins_s[3];

  // serial engine, pause control and register slave
  always_comb begin
    d         = q;
    mem_we    = 1'b0;
    mem_waddr = q.addr;
    mem_wdata = q.sh[7:0];
    bpc       = lines_of(q.io);
    amode     = q.mr[MR_MODE_HI:MR_MODE_LO];
    sck_rise  = sck_s && !q.sck_prev;
    sck_fall  = !sck_s && q.sck_prev;
    d.sck_prev = sck_s;
    // pause pin is a data line in quad
    hold_low  = !pause_n_s && (q.io != IO_QUAD);
    sel       = !cs_n_s && q.ctrl_en;
    // msb first, one to four lines per clock
    case (q.io)
      IO_DUAL: sh_n = {q.sh[29:0], io_s[1], io_s[0]};
      IO_QUAD: sh_n = {q.sh[27:0], io_s};
      default: sh_n = {q.sh[30:0], io_s[0]};
    endcase
    cnt_n = q.cnt + bpc;

    if (!sel) begin
      d.st     = ST_CMD;
      d.cnt    = '0;
      d.tx_cnt = '0;
      d.paused = 1'b0;
    end else begin
      // pause changes only with clock low
      if ((hold_low != q.paused) && (!sck_s || sck_fall)) begin
        d.paused = hold_low;
      end
      if (!q.paused && sck_rise) begin
        d.sh = sh_n;
        case (q.st)
          ST_CMD: begin
            d.cnt = cnt_n;
            if (cnt_n == INSTR_BITS) begin
              d.cnt = '0;
              d.st  = ST_IGNORE;
              case (sh_n[7:0])
                CMD_READ, CMD_WRITE: begin
                  d.st    = ST_ADDR;
                  d.is_rd = (sh_n[7:0] == CMD_READ);
                end
                READ_MODE_REG_CMD: begin
                  d.st    = ST_MRD;
                  d.first = 1'b1;
                end
                WRITE_MODE_REG_CMD: d.st = ST_MWR;
                ENTER_DUAL_CMD: if (q.io == IO_SINGLE) d.io = IO_DUAL;
                ENTER_QUAD_CMD: if (q.io == IO_SINGLE) d.io = IO_QUAD;
                EXIT_MULTI_IO_CMD: if (q.io != IO_SINGLE) d.io = IO_SINGLE;
                default: d.st = ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            d.cnt = cnt_n;
            if (cnt_n == ADDR_BITS) begin
              d.cnt  = '0;
              d.addr = sh_n[MEM_AW-1:0];
              d.st   = q.is_rd ? ST_DUMMY : ST_WDATA;
            end
          end
          ST_DUMMY: begin
            d.cnt = q.cnt + 6'h01;
            if ((q.io == IO_SINGLE && d.cnt == LAT_SINGLE) ||
                (q.io == IO_DUAL && d.cnt == LAT_DUAL) ||
                (q.io == IO_QUAD && d.cnt == LAT_QUAD)) begin
              d.cnt   = '0;
              d.st    = ST_RDATA;
              d.first = 1'b1;
            end
          end
          ST_WDATA: begin
            d.cnt = cnt_n;
            if (cnt_n == DATA_BITS) begin
              // write byte, then page or sequential
              d.cnt     = '0;
              mem_we    = 1'b1;
              mem_wdata = sh_n[7:0];
              d.addr    = next_addr(q.addr, amode);
              if (amode == AM_BYTE) d.st = ST_IGNORE;
            end
          end
          ST_MWR: begin
            d.cnt = cnt_n;
            if (cnt_n == DATA_BITS) begin
              // only mode bits kept, rest zero
              d.mr = {sh_n[MR_MODE_HI:MR_MODE_LO], 6'h00};
              d.st = ST_IGNORE;
            end
          end
          default: d.cnt = q.cnt;
        endcase
      end
      // output moves on the falling edge
      if (!q.paused && sck_fall && (q.st == ST_RDATA || q.st == ST_MRD)) begin
        if (q.tx_cnt == 4'h0 || q.tx_cnt == 4'h8) begin
          if (!q.first && (q.st == ST_MRD || amode == AM_BYTE)) begin
            d.st     = ST_IGNORE;
            d.tx_cnt = '0;
          end else begin
            // load next byte: first byte of any read, later bytes for page or sequential read
            d.first  = 1'b0;
            d.tx     = (q.st == ST_MRD) ? q.mr : mem_rdata;
            d.tx_cnt = bpc[3:0];
            if (q.st == ST_RDATA) d.addr = next_addr(q.addr, amode);
          end
        end else begin
          d.tx     = q.tx << bpc;
          d.tx_cnt = q.tx_cnt + bpc[3:0];
        end
      end
    end

    // drive only selected, pause line not held low, and sending
    d.io_oe = 4'h0;
    d.io_o  = 4'h0;
    if (sel && !hold_low && d.tx_cnt != 4'h0 &&
        (d.st == ST_RDATA || d.st == ST_MRD)) begin
      case (d.io)
        IO_DUAL: begin
          d.io_oe = 4'h3;
          d.io_o  = {2'h0, d.tx[7:6]};
        end
        IO_QUAD: begin
          d.io_oe = 4'hf;
          d.io_o  = d.tx[7:4];
        end
        default: begin
          d.io_oe = 4'h2;
          d.io_o  = {2'h0, d.tx[7], 1'b0};
        end
      endcase
    end

    // register bus: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (q.awaddr == REG_CTRL) begin
        if (q.wstrb[0]) begin
          d.ctrl_en = q.wdata[CTRL_EN_BIT];
          if (q.wdata[CTRL_EXIT_BIT]) d.io = IO_SINGLE;
        end
      end else if (q.awaddr != REG_STATUS) begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0;
      case (s_axi_araddr)
        REG_CTRL:   d.rdata = {31'h0, q.ctrl_en};
        REG_STATUS: d.rdata = {25'h0, (q.st != ST_CMD), q.paused, sel,
                               amode, q.io};
        default:    d.rresp = RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= MAIN_RST;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign io_line_o     = q.io_o;
  assign io_line_oe_o  = q.io_oe;
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

endmodule

// File: test/ssp_host.sv
// behavioural host controller driving frames onto the serial pins
`timescale 1ns/1ps
module ssp_host (
  input  logic       ref_clk_i,
  input  logic [3:0] io_line_o,
  input  logic [3:0] io_line_oe_o,
  output logic       cs_n_o,
  output logic       sck_o,
  output logic [3:0] h_out_o,
  output logic [3:0] h_oe_o
);
  int w = 1;
  // idle: deselected, clock low, pause line high
  // pause kept high
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    h_out_o = 4'h8;
    h_oe_o = 4'h8;
  end
  task automatic sel();
    cs_n_o <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic desel();
    repeat (4) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    h_oe_o <= (w == 4) ? 4'h0 : 4'h8;
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    logic [7:0] s;
    s = tx;
    for (int i = 0; i < 8 / w; i++) begin
      h_oe_o <= drv ? ((w == 4) ? 4'hf : (w == 2) ? 4'hb : 4'h9) : ((w == 4) ? 4'h0 : 4'h8);
      h_out_o <= (w == 4) ? s[7:4] : (w == 2) ? {2'h2, s[7:6]} : {3'h4, s[7]};
      repeat (4) @(posedge ref_clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rx = (w == 4) ? {rx[3:0], io_line_o} : (w == 2) ? {rx[5:0], io_line_o[1:0]}
                                                      : {rx[6:0], io_line_o[1]};
      s = s << w;
      sck_o <= 1'b0;
    end
  endtask
  task automatic hold(input int n, output logic [3:0] seen);
    h_out_o[3] <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    seen = io_line_oe_o;
    repeat (n) begin
      sck_o <= 1'b1;
      h_out_o[0] <= ~h_out_o[0];
      repeat (4) @(posedge ref_clk_i);
      sck_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
    h_out_o[3] <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule

// File: test/ssp_props.sv
// concurrent checks on the pins and register bus of ssp_top
`timescale 1ns/1ps
module ssp_props (
  input logic       ref_clk_i,
  input logic       rst_n_i,
  input logic       chip_select_n_i,
  input logic       serial_clock_i,
  input logic [3:0] io_line_i,
  input logic [3:0] io_line_o,
  input logic [3:0] io_line_oe_o,
  input logic       s_axi_awvalid,
  input logic       s_axi_awready,
  input logic       s_axi_wvalid,
  input logic       s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic       s_axi_bvalid,
  input logic       s_axi_bready,
  input logic       s_axi_arvalid,
  input logic       s_axi_arready,
  input logic       s_axi_rvalid
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // pin drive rules
  a_oe_selected: assert property (io_line_oe_o != 4'h0 |-> !$past(chip_select_n_i, 5))
    else $error("pins driven long after deselect");
  a_desel_quiet: assert property (chip_select_n_i [*4] |-> io_line_oe_o == 4'h0)
    else $error("pins driven while deselected");
  a_out_fall: assert property (io_line_oe_o[1] && $stable(io_line_oe_o) && $changed(io_line_o[1])
    |-> !$past(serial_clock_i) && !$past(serial_clock_i, 2))
    else $error("output changed outside clock low phase");
  a_pause_quiet: assert property ((!io_line_i[3]) [*4] ##0 (io_line_oe_o != 4'hf)
    |-> io_line_oe_o == 4'h0)
    else $error("pins driven while paused");
  a_oe_shape: assert property (io_line_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal output enable pattern");
  a_spare_quad: assert property (io_line_oe_o[2] |-> io_line_oe_o == 4'hf)
    else $error("spare line driven outside quad");
  // register bus answers
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  c_single: cover property (io_line_oe_o == 4'h2);
  c_dual: cover property (io_line_oe_o == 4'h3);
  c_quad: cover property (io_line_oe_o == 4'hf);
endmodule

// File: test/ssp_top_test.sv
// self-checking bench for the serial sram pin interface
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module ssp_top_test;
  import ssp_pkg::*;
  typedef struct packed {
    logic [2:0]  w;
    logic [7:0]  m;
    logic [17:0] a;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  e1;
  } ssp_row_s;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        flip = 1'b0;
  logic        cs_n, sck, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [3:0]  dev_o, dev_oe, h_out, h_oe, io_in, seen;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx, r0, r1;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic [1:0]  bresp, rresp, rd_r;
  int          bad_count = 0;
  int          cmp_count = 0;
  ssp_row_s    rows [5] = '{
    '{3'h1, 8'h40, 18'h0003f, 8'haa, 8'hbb, 8'hbb}, '{3'h1, 8'h80, 18'h0003f, 8'h11, 8'h22, 8'hbb},
    '{3'h1, 8'h00, 18'h0003f, 8'h33, 8'h44, 8'hbb}, '{3'h2, 8'h40, 18'h3ffff, 8'h55, 8'h66, 8'h66},
    '{3'h4, 8'h40, 18'h01234, 8'hc3, 8'h5a, 8'h5a}};
  // wire level from both drivers, released lines wander
  assign io_in = (dev_oe & dev_o) | (~dev_oe & h_oe & h_out) | (~dev_oe & ~h_oe & {4{flip}});
  always @(posedge ref_clk_i) flip <= ~flip;
  initial forever #50 ref_clk_i = ~ref_clk_i;
  ssp_top u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
    .serial_clock_i(sck), .io_line_i(io_in), .io_line_o(dev_o), .io_line_oe_o(dev_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  ssp_host u_host (.ref_clk_i(ref_clk_i), .io_line_o(dev_o), .io_line_oe_o(dev_oe), .cs_n_o(cs_n),
    .sck_o(sck), .h_out_o(h_out), .h_oe_o(h_oe));
  // register bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // readies settle mid-cycle; each channel drops at the edge that takes it
    while (aw_p || w_p) begin
      @(negedge ref_clk_i);
      if (awready) aw_p = 1'b0;
      if (wready) w_p = 1'b0;
      @(posedge ref_clk_i);
      awvalid <= aw_p;
      wvalid <= w_p;
    end
    do @(negedge ref_clk_i); while (!bvalid);
    `CHK("write resp", RESP_OKAY, bresp)
    @(posedge ref_clk_i);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // ready seen mid-cycle, request dropped at the edge that takes it
    do @(negedge ref_clk_i); while (!arready);
    @(posedge ref_clk_i);
    arvalid <= 1'b0;
    do @(negedge ref_clk_i); while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
    @(posedge ref_clk_i);
    rready <= 1'b0;
  endtask
  // serial frames
  task automatic op1(input logic [7:0] op, input int n, input logic [7:0] d);
    u_host.sel();
    u_host.byte_io(op, 1'b1, rx);
    if (n > 0) u_host.byte_io(d, n == 1, rx);
    u_host.desel();
  endtask
  task automatic adr(input logic [7:0] op, input logic [17:0] a);
    u_host.sel();
    u_host.byte_io(op, 1'b1, rx);
    u_host.byte_io({6'h00, a[17:16]}, 1'b1, rx);
    u_host.byte_io(a[15:8], 1'b1, rx);
    u_host.byte_io(a[7:0], 1'b1, rx);
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d0, input logic [7:0] d1);
    adr(CMD_WRITE, a);
    u_host.byte_io(d0, 1'b1, rx);
    u_host.byte_io(d1, 1'b1, rx);
    u_host.desel();
  endtask
  task automatic rd(input logic [17:0] a, input logic p);
    adr(CMD_READ, a);
    u_host.byte_io(8'h00, 1'b0, rx);
    u_host.byte_io(8'h00, 1'b0, r0);
    if (p) u_host.hold(3, seen);
    u_host.byte_io(8'h00, 1'b0, r1);
    u_host.desel();
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    #8000000;
    bad_count++;
    print_verdict();
  end
  // main sequence: table rows, then hand-written cases
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    foreach (rows[k]) begin
      if (rows[k].w != 3'h1) op1((rows[k].w == 3'h2) ? ENTER_DUAL_CMD : ENTER_QUAD_CMD, 0, 8'h00);
      u_host.w = rows[k].w;
      axi_rd(REG_STATUS);
      `CHK("io width", {1'b0, rows[k].w[2:1]}, {1'b0, rd_d[1:0]})
      op1(WRITE_MODE_REG_CMD, 1, rows[k].m);
      op1(READ_MODE_REG_CMD, 2, 8'h00);
      `CHK("mode reg", rows[k].m, rx)
      wr(rows[k].a, rows[k].d0, rows[k].d1);
      op1(WRITE_MODE_REG_CMD, 1, 8'h40);
      rd(rows[k].a, 1'b0);
      `CHK("first byte", rows[k].d0, r0)
      `CHK("second byte", rows[k].e1, r1)
      if (rows[k].w != 3'h1) op1(EXIT_MULTI_IO_CMD, 0, 8'h00);
      u_host.w = 1;
    end
    rd(18'h0003f, 1'b1);
    `CHK("paused oe", 4'h0, seen)
    `CHK("resumed byte", 8'hbb, r1)
    adr(CMD_WRITE, 18'h0003f);
    u_host.desel();
    rd(18'h0003f, 1'b0);
    `CHK("after abort", 8'h33, r0)
    axi_rd(8'h08);
    `CHK("unmapped resp", RESP_SLVERR, rd_r)
    `CHK("unmapped data", 32'h0, rd_d)
    axi_wr(REG_CTRL, 32'h0);
    wr(18'h0003f, 8'h77, 8'h77);
    axi_wr(REG_CTRL, 32'h1);
    rd(18'h0003f, 1'b0);
    `CHK("disabled write", 8'h33, r0)
    rst_n_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    `CHK("oe after reset", 4'h0, dev_oe)
    op1(READ_MODE_REG_CMD, 2, 8'h00);
    `CHK("mode default", MR_RESET, rx)
    print_verdict();
  end
endmodule
bind ssp_top ssp_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .chip_select_n_i(chip_select_n_i), .serial_clock_i(serial_clock_i), .io_line_i(io_line_i),
  .io_line_o(io_line_o), .io_line_oe_o(io_line_oe_o), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
